// ===== core/rmap_pkg.sv
// Purpose: Shared constants and types for the resource map and bus stretch
// Assumes: 32-bit AHB-Lite register access, one register per aligned word
// Notes: Register byte address is four times the register index
package rmap_pkg;
	// Register indexes; byte address = index * 4
	localparam logic [7:0] IDX_RAM_POS = 8'h10;
	localparam logic [7:0] IDX_REG_POS = 8'h11;
	localparam logic [7:0] IDX_NVS_POS = 8'h12;
	localparam logic [7:0] IDX_MISC = 8'h13;
	localparam logic [7:0] IDX_BUS_CTRL = 8'h14;
	localparam logic [7:0] IDX_STATUS = 8'h15;

	// Reset values
	localparam logic [7:0] RST_RAM_POS = 8'h08;
	localparam logic [7:0] RST_REG_POS = 8'h00;
	localparam logic [7:0] RST_NVS_POS = 8'h01;
	localparam logic [7:0] RST_MISC = 8'h00;
	localparam logic [7:0] RST_BUS_CTRL = 8'h00;

	// Writable masks; fixed-zero bits are cleared
	localparam logic [7:0] MSK_RAM_POS = 8'hf8;
	localparam logic [7:0] MSK_REG_POS = 8'hf9;
	localparam logic [7:0] MSK_NVS_POS = 8'hf1;
	localparam logic [7:0] MSK_MISC = 8'h7f;
	localparam logic [7:0] MSK_BUS_CTRL = 8'h0d;

	// Field positions
	localparam int B_MAP_WAIT_STOP = 0;
	localparam int B_NVS_READ_EN = 0;
	localparam int B_FOLLOW_NARROW = 6;
	localparam int B_FOLLOW_STR_HI = 5;
	localparam int B_FOLLOW_STR_LO = 4;
	localparam int B_EXT_STR_HI = 3;
	localparam int B_EXT_STR_LO = 2;
	localparam int B_FLASH_UPPER = 1;
	localparam int B_FLASH_EN = 0;
	localparam int B_INT_VIS = 3;
	localparam int B_EXT_WAIT_STOP = 2;
	localparam int B_PORT_E_EMU = 0;

	// Map geometry
	localparam logic [1:0] REG_SUB_BLOCK = 2'b00;
	localparam logic [1:0] FOLLOW_SUB_BLOCK = 2'b01;
	localparam logic [3:0] NVS_FIRST_PAGE = 4'hd;
	localparam logic [7:0] DBG_ROM_PAGE = 8'hff;
	localparam logic [8:0] PORT_E_DATA_OFS = 9'h008;
	localparam logic [8:0] PORT_E_DIR_OFS = 9'h009;

	// Mode straps {special_n, b, a}
	localparam logic [1:0] MODE_SINGLE = 2'b00;
	localparam logic [1:0] MODE_NARROW = 2'b01;
	localparam logic [1:0] MODE_PERIPH = 2'b10;
	localparam logic [1:0] MODE_WIDE = 2'b11;
	localparam logic [2:0] MODE_RST = 3'b000;

	typedef enum logic [1:0] {
		ST_RESET = 2'b00,
		ST_SYNC = 2'b01,
		ST_SETTLE = 2'b11,
		ST_RUN = 2'b10
	} rmap_state_type;

	typedef struct packed {
		logic dbg;
		logic regs;
		logic ram;
		logic nvs;
		logic flash;
		logic ext;
	} rmap_sel_type;

	typedef struct packed {
		logic visible;
		logic wide;
		logic [1:0] stretch;
	} rmap_ext_type;
endpackage

// ===== core/rmap_top.sv
// Purpose: Internal resource decode, mapping registers and external bus format
// Assumes: AHB-Lite slave, single word transfers, mode straps on pins
// Notes: Decode results appear one cycle after the CPU address
//
// Contract
// - Special narrow with visibility on: internal accesses shown wide, external narrow
// - Normal narrow mode never shows internal accesses; visibility bit ignored
// - Visibility and port E emulation: normal once, special anytime but first
// - External wait-stop set: finish pending activity, then shut external bus
// - Port E emulation in expanded mode moves port E registers external
// - Position registers: normal write once, special anytime, read anytime
// - Position register write takes effect one cycle later
// - Any unclaimed address decodes as external memory
// - Register block 512 bytes at base bits 15..11, reset at zero
// - Mapping wait-stop set shuts mapping access during wait mode
// - RAM one Kbyte at base bits 15..11, reset at 0x0800
// - Nonvolatile store 768 bytes, base bits 15..12, reset at 0x0d00
// - Read enable gates only array reads; resets one, forced one single-chip
// - Flash 32 Kbytes in lower or upper half; others override it
// - Flash upper select: zero low half, one high; reset by mode
// - Flash enable: zero removes flash; reset zero expanded, one single-chip
// - Miscellaneous control: read anytime, normal once, special anytime
// - Follow window narrow bit gives 8-bit bus only in expanded wide
// - Follow window sits right after register block and moves with it
// - Follow stretch bits add 0..3 E-clock stretches to window accesses
// - External stretch bits add 0..3 E-clock stretches to external accesses
`timescale 1ns/1ps
module rmap_top import rmap_pkg::*; (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic [2:0] mode_pins,
	input wire logic [15:0] cpu_addr,
	input wire logic cpu_valid,
	input wire logic debug_monitor,
	input wire logic wait_mode,
	input wire logic ext_busy,
	output rmap_sel_type sel,
	output rmap_ext_type ext_fmt,
	output logic ext_bus_off,
	output logic map_off
);

////////////////////////////////////////////////////////////////////////////////
// Mode strap capture

logic [2:0] pin_s1_q, pin_s2_q, mode_q;
rmap_state_type st_q, st_d;

always_ff @(posedge mclk or negedge rst_b) begin
	if (!rst_b) begin
		pin_s1_q <= MODE_RST;
		pin_s2_q <= MODE_RST;
	end else begin
		pin_s1_q <= mode_pins;
		pin_s2_q <= pin_s1_q;
	end
end

always_comb begin
	unique case (st_q)
		ST_RESET: st_d = ST_SYNC;
		ST_SYNC: st_d = ST_SETTLE;
		ST_SETTLE: st_d = ST_RUN;
		ST_RUN: st_d = ST_RUN;
	endcase
end

wire capture = (st_q == ST_SETTLE);

// Strap taken once after release so a pin wiggle later cannot change mode
always_ff @(posedge mclk or negedge rst_b) begin
	if (!rst_b) begin
		st_q <= ST_RESET;
		mode_q <= MODE_RST;
	end else begin
		st_q <= st_d;
		if (capture) begin
			mode_q <= pin_s2_q;
		end
	end
end

wire special = ~mode_q[2];
wire single = (mode_q[1:0] == MODE_SINGLE);
wire periph = (mode_q[1:0] == MODE_PERIPH) || (mode_q == 3'b110);
wire expanded = ~single & ~periph;
wire narrow = (mode_q[1:0] == MODE_NARROW);
wire wide = (mode_q[1:0] == MODE_WIDE);
// Mode lands on the capture edge itself, so flash reset reads the strap
wire strap_single = (pin_s2_q[1:0] == MODE_SINGLE);

////////////////////////////////////////////////////////////////////////////////
// AHB-Lite slave: writes zero wait, reads one wait state

logic wr_pend_q, rd_pend_q;
logic [7:0] idx_q;
logic hready_q;
logic [31:0] hrdata_q;

wire take = hsel & htrans[1] & hready & hreadyout;
wire [7:0] idx_a = haddr[9:2];

always_ff @(posedge mclk or negedge rst_b) begin
	if (!rst_b) begin
		wr_pend_q <= 1'b0;
		rd_pend_q <= 1'b0;
		idx_q <= 8'h00;
		hready_q <= 1'b0;
	end else begin
		wr_pend_q <= take & hwrite;
		rd_pend_q <= take & ~hwrite;
		if (take) begin
			idx_q <= idx_a;
		end
		hready_q <= (st_q == ST_RUN) & ~(take & ~hwrite);
	end
end

wire wdat_valid = wr_pend_q;
wire [7:0] wb = hwdata[7:0];
wire wr_rm = wdat_valid && idx_q == IDX_RAM_POS;
wire wr_rg = wdat_valid && idx_q == IDX_REG_POS;
wire wr_ee = wdat_valid && idx_q == IDX_NVS_POS;
wire wr_misc = wdat_valid && idx_q == IDX_MISC;
wire wr_ctrl = wdat_valid && idx_q == IDX_BUS_CTRL;

////////////////////////////////////////////////////////////////////////////////
// Mapping registers

logic [7:0] rm_q, rg_q, ee_q, misc_q, ctrl_q;
logic [3:0] once_q;
logic vis_done_q, vis_first_q;

wire ok_rm = special | ~once_q[0];
wire ok_rg = special | ~once_q[1];
wire ok_ee = special | ~once_q[2];
wire ok_misc = special | ~once_q[3];
// Special modes drop the first write, normal modes keep only the first
wire ok_vis = special ? vis_first_q : ~vis_done_q;

always_ff @(posedge mclk or negedge rst_b) begin
	if (!rst_b) begin
		rm_q <= RST_RAM_POS;
		rg_q <= RST_REG_POS;
		ee_q <= RST_NVS_POS;
		misc_q <= RST_MISC;
		once_q <= 4'h0;
	end else if (capture) begin
		misc_q[B_FLASH_UPPER] <= strap_single;
		misc_q[B_FLASH_EN] <= strap_single;
	end else begin
		if (wr_rm) begin
			once_q[0] <= 1'b1;
		end
		if (wr_rm && ok_rm) begin
			rm_q <= wb & MSK_RAM_POS;
		end
		if (wr_rg) begin
			once_q[1] <= 1'b1;
		end
		if (wr_rg && ok_rg) begin
			rg_q <= wb & MSK_REG_POS;
		end
		if (wr_ee) begin
			once_q[2] <= 1'b1;
			ee_q[B_NVS_READ_EN] <= wb[B_NVS_READ_EN] | single;
		end
		if (wr_ee && ok_ee) begin
			ee_q[7:4] <= wb[7:4];
		end
		if (wr_misc) begin
			once_q[3] <= 1'b1;
		end
		if (wr_misc && ok_misc) begin
			misc_q <= wb & MSK_MISC;
		end
	end
end

always_ff @(posedge mclk or negedge rst_b) begin
	if (!rst_b) begin
		ctrl_q <= RST_BUS_CTRL;
		vis_done_q <= 1'b0;
		vis_first_q <= 1'b0;
	end else if (wr_ctrl) begin
		vis_done_q <= 1'b1;
		vis_first_q <= 1'b1;
		ctrl_q[B_EXT_WAIT_STOP] <= wb[B_EXT_WAIT_STOP];
		if (ok_vis) begin
			ctrl_q[B_INT_VIS] <= wb[B_INT_VIS];
			ctrl_q[B_PORT_E_EMU] <= wb[B_PORT_E_EMU];
		end
	end
end

// Decode uses a delayed copy so a new position lands one cycle later
logic [7:0] rm_eff_q, rg_eff_q, ee_eff_q;

always_ff @(posedge mclk or negedge rst_b) begin
	if (!rst_b) begin
		rm_eff_q <= RST_RAM_POS;
		rg_eff_q <= RST_REG_POS;
		ee_eff_q <= RST_NVS_POS;
	end else begin
		rm_eff_q <= rm_q;
		rg_eff_q <= rg_q;
		ee_eff_q <= ee_q;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Read data

logic [7:0] rd_byte;
wire [7:0] status = {2'b00, map_off, ext_bus_off, wait_mode, mode_q};

always_comb begin
	unique case (idx_q)
		IDX_RAM_POS: rd_byte = rm_q;
		IDX_REG_POS: rd_byte = rg_q;
		IDX_NVS_POS: rd_byte = ee_q;
		IDX_MISC: rd_byte = misc_q;
		IDX_BUS_CTRL: rd_byte = ctrl_q;
		IDX_STATUS: rd_byte = status;
		default: rd_byte = 8'h00;
	endcase
end

always_ff @(posedge mclk or negedge rst_b) begin
	if (!rst_b) begin
		hrdata_q <= 32'h0000_0000;
	end else if (rd_pend_q) begin
		hrdata_q <= {24'h00_0000, rd_byte};
	end
end

assign hrdata = hrdata_q;
assign hreadyout = hready_q;

logic hresp_q;
always_ff @(posedge mclk or negedge rst_b) begin
	if (!rst_b) begin
		hresp_q <= 1'b0;
	end else begin
		hresp_q <= 1'b0;
	end
end
assign hresp = hresp_q;

////////////////////////////////////////////////////////////////////////////////
// Wait-mode shutdown

logic ext_off_q, map_off_q;
wire ext_off_d = wait_mode & ctrl_q[B_EXT_WAIT_STOP] & (ext_off_q | ~ext_busy);
wire map_off_d = wait_mode & rg_q[B_MAP_WAIT_STOP];

always_ff @(posedge mclk or negedge rst_b) begin
	if (!rst_b) begin
		ext_off_q <= 1'b0;
		map_off_q <= 1'b0;
	end else begin
		ext_off_q <= ext_off_d;
		map_off_q <= map_off_d;
	end
end

assign ext_bus_off = ext_off_q;
assign map_off = map_off_q;

////////////////////////////////////////////////////////////////////////////////
// Address decode

wire nonvolatile_read_enable = ee_eff_q[B_NVS_READ_EN] | single;
wire hit_dbg = debug_monitor && cpu_addr[15:8] == DBG_ROM_PAGE;
wire in_rg = cpu_addr[15:11] == rg_eff_q[7:3];
wire hit_rg_blk = in_rg && cpu_addr[10:9] == REG_SUB_BLOCK;
wire hit_follow = in_rg && cpu_addr[10:9] == FOLLOW_SUB_BLOCK;
wire pe_reg = cpu_addr[8:0] == PORT_E_DATA_OFS ||
	cpu_addr[8:0] == PORT_E_DIR_OFS;
wire pe_out = expanded & ctrl_q[B_PORT_E_EMU] & pe_reg;
wire hit_reg = hit_rg_blk & ~pe_out;
wire hit_ram = cpu_addr[15:11] == rm_eff_q[7:3] && !cpu_addr[10];
wire hit_nvs = nonvolatile_read_enable && cpu_addr[15:12] == ee_eff_q[7:4] &&
	cpu_addr[11:8] >= NVS_FIRST_PAGE;
wire hit_flash = misc_q[B_FLASH_EN] &&
	cpu_addr[15] == misc_q[B_FLASH_UPPER];

rmap_sel_type sel_d;
always_comb begin
	sel_d = '0;
	if (cpu_valid && !map_off_d) begin
		if (hit_dbg) begin
			sel_d.dbg = 1'b1;
		end else if (hit_reg) begin
			sel_d.regs = 1'b1;
		end else if (hit_ram) begin
			sel_d.ram = 1'b1;
		end else if (hit_nvs) begin
			sel_d.nvs = 1'b1;
		end else if (hit_flash) begin
			sel_d.flash = 1'b1;
		end else begin
			sel_d.ext = 1'b1;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// External bus format and stretch

wire internal_d = sel_d.regs | sel_d.ram | sel_d.nvs | sel_d.flash;
wire vis_ok = ctrl_q[B_INT_VIS] & expanded & (special | ~narrow);
wire follow_ext = sel_d.ext & hit_follow;

rmap_ext_type fmt_d;
always_comb begin
	fmt_d = '0;
	fmt_d.visible = sel_d.ext | (internal_d & vis_ok);
	// Visible internal cycles are always shown wide
	fmt_d.wide = (internal_d & vis_ok) |
		(sel_d.ext & wide &
		~(follow_ext & misc_q[B_FOLLOW_NARROW]));
	if (expanded && follow_ext) begin
		fmt_d.stretch = {misc_q[B_FOLLOW_STR_HI],
			misc_q[B_FOLLOW_STR_LO]};
	end else if (expanded && sel_d.ext) begin
		fmt_d.stretch = {misc_q[B_EXT_STR_HI],
			misc_q[B_EXT_STR_LO]};
	end
	if (!expanded || ext_off_d) begin
		fmt_d.visible = 1'b0;
	end
end

rmap_sel_type sel_q;
rmap_ext_type fmt_q;
always_ff @(posedge mclk or negedge rst_b) begin
	if (!rst_b) begin
		sel_q <= '0;
		fmt_q <= '0;
	end else begin
		sel_q <= sel_d;
		fmt_q <= fmt_d;
	end
end

assign sel = sel_q;
assign ext_fmt = fmt_q;

////////////////////////////////////////////////////////////////////////////////
// Checks

default clocking cb @(posedge mclk); endclocking
default disable iff (!rst_b);

sequence s_pos_write;
	wr_rg && ok_rg && !capture;
endsequence

sequence s_pos_land;
	##1 (rg_eff_q != $past(rg_eff_q) || rg_eff_q == rg_q) ##1 1'b1;
endsequence

a_debug_first: assert property (
	cpu_valid && hit_dbg && !map_off_d |=> sel_q.dbg && !sel_q.regs)
	else $error("debug ROM lost priority");

a_reg_over_ram: assert property (
	cpu_valid && !hit_dbg && hit_reg && hit_ram && !map_off_d
	|=> sel_q.regs && !sel_q.ram)
	else $error("register block lost to RAM");

a_unclaimed_ext: assert property (
	cpu_valid && !map_off_d && !hit_dbg && !hit_reg && !hit_ram &&
	!hit_nvs && !hit_flash |=> sel_q.ext)
	else $error("unclaimed address not external");

a_pos_lag: assert property (
	s_pos_write |=> rg_eff_q == $past(rg_eff_q) ##1
	rg_eff_q == (($past(wb, 2)) & MSK_REG_POS))
	else $error("position write not applied one cycle late");

a_pos_once: assert property (
	!special && once_q[1] && wr_rg |=> $stable(rg_q))
	else $error("position register rewritten in normal mode");

a_narrow_hidden: assert property (
	!special && narrow |-> !(fmt_q.visible && !sel_q.ext))
	else $error("internal access shown in normal narrow mode");

a_stretch_single: assert property (
	(single || periph) && st_q == ST_RUN |=> fmt_q.stretch == 2'b00)
	else $error("stretch outside expanded mode");

a_bus_shutdown: assert property (
	wait_mode && ctrl_q[B_EXT_WAIT_STOP] && !ext_busy ##1
	wait_mode && ctrl_q[B_EXT_WAIT_STOP] |-> ext_off_q)
	else $error("external bus not shut in wait");

a_map_gated: assert property (
	map_off_q |-> sel_q == '0)
	else $error("decode active with mapping stopped");

a_zero_bits: assert property (
	(rm_q & ~MSK_RAM_POS) == 8'h00 && (misc_q & ~MSK_MISC) == 8'h00)
	else $error("fixed zero bit set");

endmodule

// ===== sim/rmap_ext_mem.sv
// Purpose: External memory seen across the multiplexed bus
// Assumes: One external cycle per decoded external access
// Notes: Busy covers the base cycle plus every stretch cycle
`timescale 1ns/1ps
module rmap_ext_mem import rmap_pkg::*; (
	input wire logic mclk,
	input wire logic rst_b,
	input rmap_sel_type sel,
	input rmap_ext_type ext_fmt,
	output logic ext_busy
);
////////////////////////////////////////////////////////////////////////
	logic [2:0] cnt_q;
	logic [2:0] cnt_d;

	// Slow memory: each stretch adds one busy cycle
	assign cnt_d = {1'b0, ext_fmt.stretch} + 3'h1;
	// Pending activity that a wait shutdown must let finish
	assign ext_busy = (cnt_q != 3'h0);

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_q <= 3'h0;
		end else if (sel.ext) begin
			cnt_q <= cnt_d;
		end else if (cnt_q != 3'h0) begin
			cnt_q <= cnt_q - 3'h1;
		end
	end
endmodule

// ===== sim/rmap_top_tb_top.sv
// Purpose: Self-checking bench for the resource map block
// Assumes: One slave, so hready is tied to hreadyout
// Notes: Four resets cover special wide, special narrow, normal narrow and normal single
`timescale 1ns/1ps
module rmap_top_tb_top import rmap_pkg::*;;
	logic mclk, rst_b, hsel, hwrite, cpu_valid, debug_monitor, wait_mode;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize, mode_pins;
	logic [15:0] cpu_addr;
	logic hreadyout, hresp, ext_busy, ext_bus_off, map_off;
	rmap_sel_type sel;
	rmap_ext_type ext_fmt;
	logic [7:0] rdat;
	int fail_count;
	int num_checks;

	rmap_top u_rmap_top (.mclk(mclk), .rst_b(rst_b), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .mode_pins(mode_pins),
		.cpu_addr(cpu_addr), .cpu_valid(cpu_valid),
		.debug_monitor(debug_monitor), .wait_mode(wait_mode),
		.ext_busy(ext_busy), .sel(sel), .ext_fmt(ext_fmt),
		.ext_bus_off(ext_bus_off), .map_off(map_off));

	rmap_ext_mem u_rmap_ext_mem (.mclk(mclk), .rst_b(rst_b), .sel(sel),
		.ext_fmt(ext_fmt), .ext_busy(ext_busy));
////////////////////////////////////////////////////////////////////////
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	task wrap_up;
		$display("checks %0d errors %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task cmp_val(input logic [7:0] g, input logic [7:0] e);
		num_checks++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] %0t value %h exp %h", $time, g, e);
		end
	endtask

	task cmp_bit(input logic g, input logic e);
		num_checks++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] %0t flag %b exp %b", $time, g, e);
		end
	endtask

	task cmp_dec(input logic [5:0] s, input logic [3:0] f,
		input logic [3:0] m);
		num_checks++;
		if (sel !== s || (ext_fmt & m) !== (f & m)) begin
			fail_count++;
			$display("[ERR] %0t decode %h %h", $time, sel, ext_fmt);
		end
	endtask

	// Address phase held until hready, then data phase until hready
	task bus(input logic w, input logic [7:0] i, input logic [7:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {22'h0, i, 2'h0};
		do @(posedge mclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		do @(posedge mclk); while (hreadyout !== 1'b1);
		rdat = hrdata[7:0];
	endtask

	// Two spare edges let a position write reach the decoder
	task wr(input logic [7:0] i, input logic [7:0] d);
		bus(1'b1, i, d);
		repeat (2) @(posedge mclk);
	endtask

	task rd(input logic [7:0] i, input logic [7:0] e);
		bus(1'b0, i, 8'h00);
		cmp_val(rdat, e);
	endtask

	task dec(input logic [15:0] a, input logic [5:0] s,
		input logic [3:0] f, input logic [3:0] m);
		cpu_addr <= a;
		cpu_valid <= 1'b1;
		@(posedge mclk);
		@(negedge mclk);
		cmp_dec(s, f, m);
		@(posedge mclk);
	endtask

	// Straps must be steady from the release edge on
	task run(input logic [2:0] m);
		rst_b <= 1'b0;
		mode_pins <= m;
		repeat (16) @(posedge mclk);
		rst_b <= 1'b1;
		do @(posedge mclk); while (hreadyout !== 1'b1);
	endtask
////////////////////////////////////////////////////////////////////////
	task t_default;
		rd(8'h10, 8'h08);
		rd(8'h11, 8'h00);
		rd(8'h12, 8'h01);
		rd(8'h13, 8'h00);
		rd(8'h20, 8'h00);
		dec(16'h0000, 6'h10, 4'h0, 4'h0);
		dec(16'h01ff, 6'h10, 4'h0, 4'h0);
		dec(16'h0800, 6'h08, 4'h0, 4'h0);
		dec(16'h0bff, 6'h08, 4'h0, 4'h0);
		dec(16'h0c00, 6'h01, 4'hc, 4'hc);
		dec(16'h0d00, 6'h04, 4'h0, 4'h0);
		dec(16'h0fff, 6'h04, 4'h0, 4'h0);
		dec(16'h0200, 6'h01, 4'hc, 4'hf);
		dec(16'h8000, 6'h01, 4'hc, 4'hf);
	endtask

	task t_stretch;
		logic [7:0] md;
		for (int c = 0; c < 4; c++) begin
			md = {2'h1, 2'(3 - c), 2'(c), 2'h0};
			wr(8'h13, md);
			rd(8'h13, md);
			dec(16'h4000, 6'h01, {2'h3, 2'(c)}, 4'hf);
			dec(16'h0200, 6'h01, {2'h2, 2'(3 - c)}, 4'hf);
		end
	endtask

	task t_place;
		wr(8'h13, 8'h01);
		dec(16'h1000, 6'h02, 4'h0, 4'h0);
		dec(16'h0800, 6'h08, 4'h0, 4'h0);
		dec(16'h0d00, 6'h04, 4'h0, 4'h0);
		dec(16'h0000, 6'h10, 4'h0, 4'h0);
		wr(8'h13, 8'h03);
		dec(16'h9000, 6'h02, 4'h0, 4'h0);
		dec(16'h1000, 6'h01, 4'hc, 4'hc);
		debug_monitor <= 1'b1;
		dec(16'hff80, 6'h20, 4'h0, 4'h0);
		debug_monitor <= 1'b0;
		dec(16'hff80, 6'h02, 4'h0, 4'h0);
		wr(8'h11, 8'h08);
		dec(16'h0800, 6'h10, 4'h0, 4'h0);
		dec(16'h0a00, 6'h08, 4'h0, 4'h0);
		wr(8'h13, 8'h00);
		wr(8'h11, 8'hff);
		rd(8'h11, 8'hf9);
		dec(16'hf800, 6'h10, 4'h0, 4'h0);
		dec(16'hfa00, 6'h01, 4'hc, 4'hc);
		wr(8'h12, 8'h21);
		dec(16'h2d00, 6'h04, 4'h0, 4'h0);
		dec(16'h0d00, 6'h01, 4'hc, 4'hc);
		wr(8'h12, 8'h20);
		rd(8'h12, 8'h20);
		dec(16'h2d00, 6'h01, 4'hc, 4'hc);
	endtask

	task t_mapwait;
		wr(8'h11, 8'h11);
		wait_mode <= 1'b1;
		@(posedge mclk);
		dec(16'h1000, 6'h00, 4'h0, 4'h0);
		cmp_bit(map_off, 1'b1);
		wait_mode <= 1'b0;
		wr(8'h11, 8'h10);
		wait_mode <= 1'b1;
		@(posedge mclk);
		dec(16'h1000, 6'h10, 4'h0, 4'h0);
		wait_mode <= 1'b0;
	endtask

	task t_vis;
		wr(8'h14, 8'h08);
		rd(8'h14, 8'h00);
		wr(8'h14, 8'h08);
		rd(8'h14, 8'h08);
		dec(16'h0800, 6'h08, 4'hc, 4'hc);
		dec(16'h4000, 6'h01, 4'h8, 4'hf);
	endtask

	task t_wait;
		wr(8'h14, 8'h0c);
		wr(8'h13, 8'h0c);
		cpu_addr <= 16'h4000;
		cpu_valid <= 1'b1;
		repeat (2) @(posedge mclk);
		cpu_valid <= 1'b0;
		wait_mode <= 1'b1;
		@(posedge mclk);
		@(negedge mclk);
		cmp_bit(ext_bus_off, 1'b0);
		repeat (6) @(posedge mclk);
		cmp_bit(ext_bus_off, 1'b1);
		wait_mode <= 1'b0;
		wr(8'h14, 8'h08);
		wait_mode <= 1'b1;
		repeat (6) @(posedge mclk);
		cmp_bit(ext_bus_off, 1'b0);
		wait_mode <= 1'b0;
	endtask

	task t_once;
		wr(8'h14, 8'h09);
		rd(8'h14, 8'h09);
		wr(8'h14, 8'h00);
		rd(8'h14, 8'h09);
		dec(16'h0800, 6'h08, 4'h0, 4'h8);
		dec(16'h0008, 6'h01, 4'h8, 4'hc);
		dec(16'h0009, 6'h01, 4'h8, 4'hc);
		dec(16'h000a, 6'h10, 4'h0, 4'h0);
		wr(8'h10, 8'h10);
		wr(8'h10, 8'h18);
		rd(8'h10, 8'h10);
		dec(16'h1000, 6'h08, 4'h0, 4'h0);
		wr(8'h11, 8'h08);
		wr(8'h11, 8'h00);
		rd(8'h11, 8'h08);
		wr(8'h13, 8'h04);
		wr(8'h13, 8'h08);
		rd(8'h13, 8'h04);
	endtask

	task t_single;
		rd(8'h13, 8'h03);
		dec(16'h8000, 6'h02, 4'h0, 4'h0);
		wr(8'h14, 8'h01);
		dec(16'h0008, 6'h10, 4'h0, 4'h0);
		wr(8'h12, 8'h00);
		rd(8'h12, 8'h01);
		dec(16'h0d00, 6'h04, 4'h0, 4'h0);
	endtask
////////////////////////////////////////////////////////////////////////
	// Whole run is a few hundred cycles; this limit is far beyond it
	initial begin
		repeat (30000) @(posedge mclk);
		fail_count++;
		wrap_up;
	end

	initial begin
		fail_count = 0;
		num_checks = 0;
		rst_b = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		mode_pins = 3'h3;
		cpu_addr = 16'h0;
		cpu_valid = 1'b0;
		debug_monitor = 1'b0;
		wait_mode = 1'b0;
		run(3'h3);
		t_default;
		t_stretch;
		t_place;
		t_mapwait;
		run(3'h1);
		t_vis;
		t_wait;
		run(3'h5);
		t_once;
		run(3'h4);
		t_single;
		wrap_up;
	end
endmodule
